/* core/fis_cfg.svh */
`ifndef FIS_CFG_SVH
`define FIS_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FIS_ADDR_W 16
`define FIS_DATA_W 16
`define FIS_INT_STATUS_ADDR 16'hF241

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FIS_BIT_MASTER 15
`define FIS_BIT_LOAD 7
`define FIS_BIT_PROG 6
`define FIS_BIT_ERASE 5
`define FIS_BIT_RSTD 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FIS_COLD_VALUE 16'h8080
`define FIS_WARM_VALUE 16'h8010

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FIS_CMD_LOAD_A 16'h0000
`define FIS_CMD_LOAD_B 16'h0013
`define FIS_CMD_PROG_A 16'h0080
`define FIS_CMD_PROG_B 16'h001A
`define FIS_CMD_PROG_C 16'h001B
`define FIS_CMD_ERASE_A 16'h0094
`define FIS_CMD_ERASE_B 16'h0095
`define FIS_CMD_ERASE_C 16'h0030
`define FIS_CMD_RST_A 16'h00B0
`define FIS_CMD_RST_B 16'h00F0
`define FIS_CMD_RST_C 16'h00F3
`define FIS_CMD_MISC_A 16'h0065
`define FIS_CMD_MISC_B 16'h0023
`define FIS_CMD_MISC_C 16'h0071
`define FIS_CMD_MISC_D 16'h002A
`define FIS_CMD_MISC_E 16'h002C

`endif

/* core/fis_pkg.sv */
package fis_pkg;
  `include "fis_cfg.svh"

  typedef logic [`FIS_DATA_W-1:0] fis_word_t;
  typedef logic [`FIS_ADDR_W-1:0] fis_addr_t;

  // Reset tracking; one-hot so that a release is a single-bit exit
  typedef enum logic [3:0] {
    PH_RUN  = 4'h1,
    PH_COLD = 4'h2,
    PH_WARM = 4'h4,
    PH_HOT  = 4'h8
  } fis_phase_t;

  typedef struct packed {
    fis_phase_t phase;
    logic master;
    logic load;
    logic prog;
    logic erase;
    logic rstd;
    fis_word_t rdata;
  } fis_state_t;
endpackage

/* core/fis_cmd_decode.sv */
`timescale 1ns/1ns
module fis_cmd_decode
  import fis_pkg::*;
(
  input wire logic cmd_done_i,
  input wire fis_pkg::fis_word_t cmd_code_i,
  input wire logic load_data_done_i,
  input wire logic boot_done_i,
  output logic load_evt_o,
  output logic prog_evt_o,
  output logic erase_evt_o,
  output logic rstd_evt_o,
  output logic misc_evt_o
);

  function automatic logic is3(input fis_word_t c, input fis_word_t a, input fis_word_t b,
                               input fis_word_t d);
    is3 = (c == a) || (c == b) || (c == d);
  endfunction

  always_comb begin
    load_evt_o = load_data_done_i || boot_done_i ||
                 (cmd_done_i && ((cmd_code_i == `FIS_CMD_LOAD_A) ||
                                 (cmd_code_i == `FIS_CMD_LOAD_B)));
    prog_evt_o = cmd_done_i &&
                 is3(cmd_code_i, `FIS_CMD_PROG_A, `FIS_CMD_PROG_B, `FIS_CMD_PROG_C);
    erase_evt_o = cmd_done_i &&
                  is3(cmd_code_i, `FIS_CMD_ERASE_A, `FIS_CMD_ERASE_B, `FIS_CMD_ERASE_C);
    rstd_evt_o = cmd_done_i &&
                 is3(cmd_code_i, `FIS_CMD_RST_A, `FIS_CMD_RST_B, `FIS_CMD_RST_C);
    misc_evt_o = cmd_done_i &&
                 (is3(cmd_code_i, `FIS_CMD_MISC_A, `FIS_CMD_MISC_B, `FIS_CMD_MISC_C) ||
                  (cmd_code_i == `FIS_CMD_MISC_D) || (cmd_code_i == `FIS_CMD_MISC_E));
  end

endmodule

/* core/fis_irq_status.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
// Notes on behaviour
// - Master sets on any flag set, misc commands
// - Zero write or reset clears master, load, program, erase
// - Interrupt pin follows master flag directly
// - Cleared master drives pin to inactive polarity
// - Load completion or boot sets load flag
// - Program commands completing set program flag
// - Erase commands completing set erase flag
// - Reset commands or warm/hot release set reset flag
// - Reset flag cleared only by host zero write
// - Cold sets 8080h bits and keeps the reset flag, warm/hot gives 8010h
// - Status register at F241h, reserved bits zero
module fis_irq_status
  import fis_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire fis_pkg::fis_addr_t addr_i,
  input wire fis_pkg::fis_word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output fis_pkg::fis_word_t rdata_o,
  input wire logic cmd_done_i,
  input wire fis_pkg::fis_word_t cmd_code_i,
  input wire logic load_data_done_i,
  input wire logic boot_done_i,
  input wire logic cold_rst_i,
  input wire logic warm_rst_i,
  input wire logic hot_rst_i,
  input wire logic irq_pin_polarity_i,
  output logic int_o,
  output logic load_done_flag_o,
  output logic program_done_flag_o,
  output logic erase_done_flag_o,
  output logic reset_done_flag_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fis_state_t st_ff;
  fis_state_t nxt_st;

  logic load_evt;
  logic prog_evt;
  logic erase_evt;
  logic rstd_evt;
  logic misc_evt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Set dominates the host clear so a completion is never lost to a same-cycle clear
  function automatic logic upd_flag(input logic cur, input logic set, input logic clr);
    upd_flag = set | (cur & ~clr);
  endfunction

  function automatic fis_word_t pack_status(input fis_state_t s);
    fis_word_t v;
    v = '0;
    v[`FIS_BIT_MASTER] = s.master;
    v[`FIS_BIT_LOAD] = s.load;
    v[`FIS_BIT_PROG] = s.prog;
    v[`FIS_BIT_ERASE] = s.erase;
    v[`FIS_BIT_RSTD] = s.rstd;
    pack_status = v;
  endfunction

  // ----------------------------------------------------------------
  // Completion decode
  // ----------------------------------------------------------------
  fis_cmd_decode u_decode (
    .cmd_done_i(cmd_done_i),
    .cmd_code_i(cmd_code_i),
    .load_data_done_i(load_data_done_i),
    .boot_done_i(boot_done_i),
    .load_evt_o(load_evt),
    .prog_evt_o(prog_evt),
    .erase_evt_o(erase_evt),
    .rstd_evt_o(rstd_evt),
    .misc_evt_o(misc_evt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_hit;
    logic in_reset;
    logic rel_cold;
    logic rel_warm;
    logic rel_hot;
    logic set_load;
    logic set_prog;
    logic set_erase;
    logic set_rstd;
    wr_hit = 1'b0;
    in_reset = 1'b0;
    rel_cold = 1'b0;
    rel_warm = 1'b0;
    rel_hot = 1'b0;
    set_load = 1'b0;
    set_prog = 1'b0;
    set_erase = 1'b0;
    set_rstd = 1'b0;
    nxt_st = st_ff;

    // Reset phase tracking; cold outranks warm, warm outranks hot
    unique case (st_ff.phase)
      PH_RUN: begin
        if (cold_rst_i) begin
          nxt_st.phase = PH_COLD;
        end else if (warm_rst_i) begin
          nxt_st.phase = PH_WARM;
        end else if (hot_rst_i) begin
          nxt_st.phase = PH_HOT;
        end
      end
      PH_COLD: begin
        if (!cold_rst_i) begin
          nxt_st.phase = PH_RUN;
          rel_cold = 1'b1;
        end
      end
      PH_WARM: begin
        if (cold_rst_i) begin
          nxt_st.phase = PH_COLD;
        end else if (!warm_rst_i) begin
          nxt_st.phase = PH_RUN;
          rel_warm = 1'b1;
        end
      end
      PH_HOT: begin
        if (cold_rst_i) begin
          nxt_st.phase = PH_COLD;
        end else if (warm_rst_i) begin
          nxt_st.phase = PH_WARM;
        end else if (!hot_rst_i) begin
          nxt_st.phase = PH_RUN;
          rel_hot = 1'b1;
        end
      end
      default: begin
        nxt_st.phase = PH_RUN;
      end
    endcase

    in_reset = cold_rst_i || warm_rst_i || hot_rst_i;
    wr_hit = wr_i && (addr_i == `FIS_INT_STATUS_ADDR);

    // Flag set events, only on the 0 to 1 step
    set_load = load_evt && !st_ff.load;
    set_prog = prog_evt && !st_ff.prog;
    set_erase = erase_evt && !st_ff.erase;
    set_rstd = (rstd_evt || rel_warm || rel_hot) && !st_ff.rstd;

    // Only a written zero clears; a written one is a no-op
    nxt_st.load = upd_flag(st_ff.load, load_evt,
                           wr_hit && !wdata_i[`FIS_BIT_LOAD]);
    nxt_st.prog = upd_flag(st_ff.prog, prog_evt,
                           wr_hit && !wdata_i[`FIS_BIT_PROG]);
    nxt_st.erase = upd_flag(st_ff.erase, erase_evt,
                            wr_hit && !wdata_i[`FIS_BIT_ERASE]);
    nxt_st.rstd = upd_flag(st_ff.rstd, rstd_evt || rel_warm || rel_hot,
                           wr_hit && !wdata_i[`FIS_BIT_RSTD]);
    nxt_st.master = upd_flag(st_ff.master,
                             set_load || set_prog || set_erase || set_rstd || misc_evt,
                             wr_hit && !wdata_i[`FIS_BIT_MASTER]);

    // Reset in progress overrides completions; reset flag survives
    if (in_reset) begin
      nxt_st.master = 1'b0;
      nxt_st.load = 1'b0;
      nxt_st.prog = 1'b0;
      nxt_st.erase = 1'b0;
    end

    // Defaults loaded at release of each reset kind; a release while
    // another reset still runs loads nothing, so that reset keeps clearing
    if (rel_cold && !in_reset) begin
      nxt_st.master = 1'(`FIS_COLD_VALUE >> `FIS_BIT_MASTER);
      nxt_st.load = 1'b1;
    end
    if ((rel_warm || rel_hot) && !in_reset) begin
      nxt_st.master = 1'b1;
      nxt_st.rstd = 1'b1;
    end

    // Read data stand one cycle; unmapped or idle reads zero
    nxt_st.rdata = '0;
    if (rd_i && (addr_i == `FIS_INT_STATUS_ADDR)) begin
      nxt_st.rdata = pack_status(st_ff);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_ff.phase <= PH_RUN;
      st_ff.master <= 1'b1;
      st_ff.load <= 1'b1;
      st_ff.prog <= 1'b0;
      st_ff.erase <= 1'b0;
      st_ff.rstd <= 1'b0;
      st_ff.rdata <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin is a plain gate on the master flop, no enable in the path
  assign int_o = irq_pin_polarity_i ? st_ff.master : !st_ff.master;
  assign rdata_o = st_ff.rdata;
  assign load_done_flag_o = st_ff.load;
  assign program_done_flag_o = st_ff.prog;
  assign erase_done_flag_o = st_ff.erase;
  assign reset_done_flag_o = st_ff.rstd;

endmodule

/* dv/fis_host_model.sv */
`timescale 1ns/1ns
module fis_host_model (
  input wire logic clk_i,
  input wire logic irq_pin_i,
  input wire logic pol_i,
  output logic irq_seen_o
);
  // Host samples the pin as a level; no edge latch, so a clear shows at the next clock edge
  always_ff @(posedge clk_i) begin
    irq_seen_o <= (irq_pin_i == pol_i);
  end
endmodule

/* dv/fis_irq_status_asserts.sv */
`timescale 1ns/1ns
module fis_irq_status_asserts
  import fis_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire fis_pkg::fis_addr_t addr_i,
  input wire fis_pkg::fis_word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire fis_pkg::fis_word_t rdata_o,
  input wire logic cmd_done_i,
  input wire fis_pkg::fis_word_t cmd_code_i,
  input wire logic load_data_done_i,
  input wire logic boot_done_i,
  input wire logic cold_rst_i,
  input wire logic warm_rst_i,
  input wire logic hot_rst_i,
  input wire logic irq_pin_polarity_i,
  input wire logic int_o,
  input wire logic load_done_flag_o,
  input wire logic program_done_flag_o,
  input wire logic erase_done_flag_o,
  input wire logic reset_done_flag_o
);
  logic m;
  logic hit;
  logic rs;
  // Master is recovered from the pin, so pin faults show here too
  assign m = (int_o == irq_pin_polarity_i);
  assign hit = (addr_i == 16'hF241);
  assign rs = cold_rst_i | warm_rst_i | hot_rst_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd; rd_i && hit |=> rdata_o == {$past(m), 7'h00, $past(load_done_flag_o),
    $past(program_done_flag_o), $past(erase_done_flag_o), $past(reset_done_flag_o), 4'h0};
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_idle; !rd_i || !hit |=> rdata_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_prog; cmd_done_i && !rs && !program_done_flag_o &&
    cmd_code_i inside {16'h0080, 16'h001A, 16'h001B} |=> program_done_flag_o && m; endproperty
  a_prog: assert property (p_prog) else $error("program flag not set");
  property p_erase; cmd_done_i && !rs && !erase_done_flag_o &&
    cmd_code_i inside {16'h0094, 16'h0095, 16'h0030} |=> erase_done_flag_o && m; endproperty
  a_erase: assert property (p_erase) else $error("erase flag not set");
  property p_load; (load_data_done_i || boot_done_i) && !rs |=> load_done_flag_o; endproperty
  a_load: assert property (p_load) else $error("load flag not set");
  property p_rclr; rs |=> !load_done_flag_o && !program_done_flag_o && !erase_done_flag_o && !m;
  endproperty
  a_rclr: assert property (p_rclr) else $error("flags kept in reset");
  property p_rkeep; reset_done_flag_o && !(wr_i && hit && !wdata_i[4]) |=> reset_done_flag_o;
  endproperty
  a_rkeep: assert property (p_rkeep) else $error("reset flag lost");
  property p_warm; $fell(warm_rst_i) && !cold_rst_i && !hot_rst_i |=> reset_done_flag_o && m;
  endproperty
  a_warm: assert property (p_warm) else $error("warm release flag");
  property p_zero; wr_i && hit && !wdata_i[6] && !cmd_done_i |=> !program_done_flag_o; endproperty
  a_zero: assert property (p_zero) else $error("zero write kept flag");
endmodule
bind fis_irq_status fis_irq_status_asserts u_fis_irq_status_asserts (.clk_i, .rst_n_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .cmd_done_i, .cmd_code_i, .load_data_done_i, .boot_done_i,
  .cold_rst_i, .warm_rst_i, .hot_rst_i, .irq_pin_polarity_i, .int_o, .load_done_flag_o,
  .program_done_flag_o, .erase_done_flag_o, .reset_done_flag_o);

/* dv/fis_irq_status_tb.sv */
`timescale 1ns/1ns
module fis_irq_status_tb;
  import fis_pkg::*;
  logic clk_i = 1'h0, rst_n_i = 1'h0, wr = 1'h0, rd = 1'h0, cmd = 1'h0, ldd = 1'h0;
  logic boot = 1'h0, cold = 1'h0, warm = 1'h0, hot = 1'h0, pol = 1'h1, int_o, irq_seen;
  fis_addr_t addr = 16'h0000, ua;
  logic [3:0] flg;
  fis_word_t wdata = 16'h0000, code = 16'h0000, rdata, v, w;
  int n_errors = 0, num_checks = 0, cyc = 0, ks[3] = '{1, 2, 0};
  fis_word_t codes[16] = '{16'h0000, 16'h0013, 16'h0080, 16'h001A, 16'h001B, 16'h0094,
    16'h0095, 16'h0030, 16'h00B0, 16'h00F0, 16'h00F3, 16'h0065, 16'h0023, 16'h0071,
    16'h002A, 16'h002C};
  always #10 clk_i = ~clk_i;
  fis_irq_status u_fis_irq_status (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmd_done_i(cmd), .cmd_code_i(code),
    .load_data_done_i(ldd), .boot_done_i(boot), .cold_rst_i(cold), .warm_rst_i(warm),
    .hot_rst_i(hot), .irq_pin_polarity_i(pol), .int_o(int_o), .load_done_flag_o(flg[3]),
    .program_done_flag_o(flg[2]), .erase_done_flag_o(flg[1]), .reset_done_flag_o(flg[0]));
  fis_host_model u_fis_host_model (.clk_i(clk_i), .irq_pin_i(int_o), .pol_i(pol),
    .irq_seen_o(irq_seen));
  function automatic fis_word_t exp_of(input fis_word_t c);
    case (c)
      16'h0000, 16'h0013: exp_of = 16'h8080;
      16'h0080, 16'h001A, 16'h001B: exp_of = 16'h8040;
      16'h0094, 16'h0095, 16'h0030: exp_of = 16'h8020;
      16'h00B0, 16'h00F0, 16'h00F3: exp_of = 16'h8010;
      default: exp_of = 16'h8000;
    endcase
  endfunction
  task automatic chk(input fis_word_t seen, input fis_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input fis_addr_t a, input fis_word_t d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input fis_addr_t a, output fis_word_t d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic ev(input int k, input fis_word_t c);
    @(posedge clk_i);
    code <= c;
    cmd <= (k == 0);
    ldd <= (k == 1);
    boot <= (k == 2);
    @(posedge clk_i);
    {cmd, ldd, boot} <= 3'h0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hA4E323BC));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd_reg(16'hF241, v);
    chk(v, 16'h8080);
    chk({15'h0, irq_seen}, 16'h0001);
    $display("test 1 done");
    for (int i = 0; i < 18; i++) begin
      @(posedge clk_i);
      pol <= 1'($urandom);
      wr_reg(16'hF241, 16'h0000);
      rd_reg(16'hF241, v);
      chk(v, 16'h0000);
      chk({15'h0, irq_seen}, 16'h0000);
      ev(i < 16 ? 0 : i - 15, codes[i % 16]);
      rd_reg(16'hF241, v);
      chk(v, i < 16 ? exp_of(codes[i % 16]) : 16'h8080);
      chk({15'h0, irq_seen}, 16'h0001);
    end
    $display("test 2 done");
    for (int i = 0; i < 20; i++) begin
      wr_reg(16'hF241, 16'h0000);
      ev(0, 16'h0080);
      ev(0, 16'h0094);
      ev(1, 16'h0000);
      ev(0, 16'h00F0);
      w = 16'($urandom);
      // Unmapped address differs from the status one in at least one bit
      ua = (i % 2) ? 16'hF241 : 16'hF241 ^ 16'($urandom % 255 + 1);
      wr_reg(ua, w);
      rd_reg(16'hF241, v);
      chk(v, (i % 2) ? 16'h80F0 & w : 16'h80F0);
      chk({12'h000, flg}, {12'h000, ((i % 2) ? 4'hF & w[7:4] : 4'hF)});
      rd_reg(16'hF241 ^ 16'h0100, v);
      chk(v, 16'h0000);
    end
    $display("test 3 done");
    wr_reg(16'hF241, 16'h0000);
    // Ones written over cleared flags must not set them
    wr_reg(16'hF241, 16'hFFFF);
    rd_reg(16'hF241, v);
    chk(v, 16'h0000);
    foreach (ks[j]) begin
      ev(0, 16'h001A);
      @(posedge clk_i);
      {cold, warm, hot} <= {ks[j] == 0, ks[j] == 1, ks[j] == 2};
      // Event inside the reset window must be lost
      ev(0, 16'h0080);
      @(posedge clk_i);
      {cold, warm, hot} <= 3'h0;
      rd_reg(16'hF241, v);
      chk(v, ks[j] == 0 ? 16'h8090 : 16'h8010);
    end
    $display("test 4 done");
    finish_test();
  end
endmodule
